// file: adc_cfg_pkg.sv
package adc_cfg_pkg;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WORD = 2'b01,
		PH_PATTERN = 2'b10
	} phase_t;
	typedef enum logic [3:0] {
		SCAN_MANUAL = 4'b0000,
		SCAN_REPEAT = 4'b0001,
		ASCENDING_SCAN_INT_CLK = 4'b0010,
		ASCENDING_SCAN_EXT_CLK = 4'b0011,
		TOP_SCAN_INT_CLK = 4'b0100,
		TOP_SCAN_EXT_CLK = 4'b0101,
		BITMAP_SCAN_INT_CLK = 4'b0110,
		BITMAP_SCAN_EXT_CLK = 4'b0111,
		SEQUENCE_SCAN = 4'b1000
	} scan_mode_t;
	typedef struct packed {
		scan_mode_t mode;
		logic [3:0] single_channel_pick;
		logic [15:0] custom_channel_bitmap;
	} scan_sel_t;
	typedef struct packed {
		logic pair;
		logic bipolar;
		logic vs_common;
	} coding_t;
	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] sck_s;
		logic [1:0] din_s;
		phase_t phase;
		logic next_pat;
		logic [15:0] shift;
		logic [4:0] bitcnt;
		logic [8:0] nib_cnt;
		logic [7:0] pend_len;
		logic [8:0] pend_cnt;
		logic pend_rdy;
		logic [7:0] act_len;
		logic [8:0] act_cnt;
		logic bank;
		logic [7:0] pair_pseudo_diff_bit;
		logic common_input_enable;
		logic [7:0] pair_fully_diff_bit;
		logic valid;
		logic [14:0] mode_word;
		logic mode_stb;
		logic [3:0] seq_ch;
		logic [15:0] sel_mask;
		coding_t coding;
	} state_t;
endpackage

// file: adc_cfg_regs.svh
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH
// ************************************************************
// Serial word layout and register select codes.
// ************************************************************
`define WORD_BITS 5'h10
`define CFG_FLAG_BIT 15
`define SEL_HI 15
`define SEL_LO 11
`define FIELD_HI 10
`define FIELD_LO 3
`define COMMON_BIT 2
`define PSEUDO_DIFF_SELECT_CODE 5'h11
`define FULLY_DIFF_SELECT_CODE 5'h12
`define SEQUENCE_LENGTH_CODE 5'h16
`define PAIR_BITS_RST 8'h00
`define COMMON_RST 1'h0
`define SEQ_LEN_RST 8'h00
`define SHARED_COMMON_INPUT 4'hF
`define INPUT_CHANNEL_ZERO 4'h0
`define NIBBLE_LAST 2'h3
`define LAST_WORD_BIT 5'h0F
`endif

// file: adc_input_config_sequencer.sv
// Operation
// - Channel pick field in single-pick scans, channel bitmap in bitmap scans.
// - Hold a sequence length; up to 256 entries in any order.
// - Each sequence entry is one 4-bit channel nibble, decoded in that form.
// - New sequence becomes active at the next chip-select falling edge.
// - Entries past the last received nibble read as channel zero.
// - Nibbles beyond the length are dropped until chip select rises.
// - A nibble cut off by frame end is not stored and reads as channel zero.
// - All pair bits and common bit clear: single-ended straight binary.
// - Pseudo-differential bit only: pair converted unipolar straight binary.
// - Bipolar bit only: pair converted fully differential, two's complement.
// - Both pair bits set: pseudo-differential wins, unipolar straight binary.
// - Common bit set: channels 0 to 14 against channel 15, unipolar.
// - The same coding table applies to every even/odd pair.
// - Code 10001 loads pseudo-diff pair bits 10:3 and common bit 2.
// - Code 10010 loads fully differential pair bits 10:3.
// - Word MSB one is a configuration write, zero a mode instruction.
// - Code 10110 loads 8-bit length field; length is field plus one.
// - Config during conversion invalidates data until a mode instruction.
`timescale 1ns/100ps
`include "adc_cfg_regs.svh"
module adc_input_config_sequencer (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic DIN,
	input wire logic CONV_BUSY,
	input wire adc_cfg_pkg::scan_sel_t SCAN_SEL,
	input wire logic [3:0] CONV_CHANNEL,
	input wire logic [7:0] SEQ_INDEX,
	output logic [15:0] SEL_MASK,
	output adc_cfg_pkg::coding_t CODING,
	output logic [3:0] SEQ_CHANNEL,
	output logic [7:0] SEQUENCE_LENGTH_FIELD,
	output logic SEQ_PENDING,
	output logic DATA_VALID,
	output logic [14:0] MODE_WORD,
	output logic MODE_STROBE
);
	import adc_cfg_pkg::*;

	// ************************************************************
	// Decode helpers.
	// ************************************************************

	// Coding of one channel from the pair bits and the common bit.
	function automatic coding_t decode_coding(
		input logic [3:0] ch,
		input logic [7:0] uni,
		input logic [7:0] bip,
		input logic com
	);
		coding_t c;
		logic [2:0] bit_ix;
		c = '0;
		bit_ix = 3'h7 - ch[3:1];
		if (com && ch != `SHARED_COMMON_INPUT) begin
			c.vs_common = 1'b1;
		end else if (uni[bit_ix]) begin
			c.pair = 1'b1;
		end else if (bip[bit_ix]) begin
			c.pair = 1'b1;
			c.bipolar = 1'b1;
		end
		// All bits clear leaves a single-ended straight binary result.
		return c;
	endfunction

	// Channel mask for the active scan mode.
	function automatic logic [15:0] select_mask(input scan_sel_t s);
		logic [15:0] m;
		m = '0;
		if (s.mode == BITMAP_SCAN_INT_CLK || s.mode == BITMAP_SCAN_EXT_CLK) begin
			m = s.custom_channel_bitmap;
		end else begin
			m[s.single_channel_pick] = 1'b1;
		end
		return m;
	endfunction

	// ************************************************************
	// State and sequence memory.
	// ************************************************************

	state_t q;
	state_t d;
	logic [3:0] seq_mem [0:511];
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic word_done;
	logic [15:0] word;
	logic [7:0] cfg_field;
	logic mem_we;
	logic [8:0] mem_addr;
	logic [3:0] mem_data;
	logic [3:0] mem_rd;

	// Edges are taken from the second and third stages only, never the first.
	assign cs_fall = q.cs_s[2] & ~q.cs_s[1];
	assign cs_rise = ~q.cs_s[2] & q.cs_s[1];
	assign sck_rise = ~q.sck_s[2] & q.sck_s[1] & ~q.cs_s[1];
	assign word = {q.shift[14:0], q.din_s[1]};
	assign cfg_field = word[`FIELD_HI:`FIELD_LO];
	assign word_done = sck_rise && q.phase == PH_WORD && q.bitcnt == `LAST_WORD_BIT;
	assign mem_rd = seq_mem[{q.bank, SEQ_INDEX}];

	// ************************************************************
	// Next-state logic.
	// ************************************************************

	// The link clock is slow against CLOCK, so each edge is seen once.
	always_comb begin
		d = q;
		d.mode_stb = 1'b0;
		mem_we = 1'b0;
		mem_addr = {~q.bank, q.nib_cnt[7:0]};
		mem_data = word[3:0];
		d.cs_s = {q.cs_s[1:0], CS_N};
		d.sck_s = {q.sck_s[1:0], SCLK};
		d.din_s = {q.din_s[0], DIN};
		if (cs_fall) begin
			d.bitcnt = '0;
			d.nib_cnt = '0;
			if (q.next_pat) begin
				d.phase = PH_PATTERN;
				d.next_pat = 1'b0;
			end else begin
				d.phase = PH_WORD;
				if (q.pend_rdy) begin
					d.act_len = q.pend_len;
					d.act_cnt = q.pend_cnt;
					d.bank = ~q.bank;
					d.pend_rdy = 1'b0;
				end
			end
		end else if (cs_rise) begin
			if (q.phase == PH_PATTERN) begin
				// A partial nibble is never counted, so it reads as zero.
				d.pend_cnt = q.nib_cnt;
				d.pend_rdy = 1'b1;
			end
			d.phase = PH_IDLE;
		end else if (sck_rise) begin
			unique case (q.phase)
				PH_IDLE: begin
				end
				PH_WORD: begin
					// Bits past the sixteenth are ignored.
					if (q.bitcnt < `WORD_BITS) begin
						d.shift = word;
						d.bitcnt = q.bitcnt + 5'h01;
					end
				end
				PH_PATTERN: begin
					d.shift = word;
					d.bitcnt = {3'h0, q.bitcnt[1:0] + 2'h1};
					if (q.bitcnt[1:0] == `NIBBLE_LAST && q.nib_cnt <= {1'b0, q.pend_len}) begin
						mem_we = 1'b1;
						d.nib_cnt = q.nib_cnt + 9'h001;
					end
					// Surplus nibbles fall through untouched.
				end
			endcase
		end
		if (word_done) begin
			if (word[`CFG_FLAG_BIT]) begin
				unique case (word[`SEL_HI:`SEL_LO])
					`PSEUDO_DIFF_SELECT_CODE: begin
						d.pair_pseudo_diff_bit = cfg_field;
						d.common_input_enable = word[`COMMON_BIT];
					end
					`FULLY_DIFF_SELECT_CODE: begin
						d.pair_fully_diff_bit = cfg_field;
					end
					`SEQUENCE_LENGTH_CODE: begin
						d.pend_len = cfg_field;
						d.next_pat = 1'b1;
						d.pend_rdy = 1'b0;
					end
					default: begin
					end
				endcase
				if (CONV_BUSY) begin
					d.valid = 1'b0;
				end
			end else begin
				d.mode_word = word[14:0];
				d.mode_stb = 1'b1;
				d.valid = 1'b1;
			end
		end
		// Entries beyond the received count read as channel zero.
		if ({1'b0, SEQ_INDEX} < q.act_cnt) begin
			d.seq_ch = mem_rd;
		end else begin
			d.seq_ch = `INPUT_CHANNEL_ZERO;
		end
		d.sel_mask = select_mask(SCAN_SEL);
		d.coding = decode_coding(CONV_CHANNEL, q.pair_pseudo_diff_bit,
			q.pair_fully_diff_bit, q.common_input_enable);
	end

	// State register; chip select idles high, so its stages reset high.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.cs_s <= 3'h7;
		end else if (CE) begin
			q <= d;
		end
	end

	// Pattern goes to the idle bank so the live sequence never changes mid-scan.
	always_ff @(posedge CLOCK) begin
		if (CE && mem_we) begin
			seq_mem[mem_addr] <= mem_data;
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************

	assign SEL_MASK = q.sel_mask;
	assign CODING = q.coding;
	assign SEQ_CHANNEL = q.seq_ch;
	assign SEQUENCE_LENGTH_FIELD = q.act_len;
	assign SEQ_PENDING = q.pend_rdy;
	assign DATA_VALID = q.valid;
	assign MODE_WORD = q.mode_word;
	assign MODE_STROBE = q.mode_stb;

	// ************************************************************
	// Checks.
	// ************************************************************

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	property p_uni_load;
		CE && word_done && word[15:11] == `PSEUDO_DIFF_SELECT_CODE
			|=> q.pair_pseudo_diff_bit == $past(cfg_field);
	endproperty
	a_uni_load: assert property (p_uni_load) else $error("pseudo-diff bits not loaded");

	property p_bip_load;
		CE && word_done && word[15:11] == `FULLY_DIFF_SELECT_CODE
			|=> q.pair_fully_diff_bit == $past(cfg_field);
	endproperty
	a_bip_load: assert property (p_bip_load) else $error("bipolar bits not loaded");

	property p_len_load;
		CE && word_done && word[15:11] == `SEQUENCE_LENGTH_CODE
			|=> q.pend_len == $past(cfg_field) && q.next_pat;
	endproperty
	a_len_load: assert property (p_len_load) else $error("length field not held");

	property p_commit;
		CE && cs_fall && q.pend_rdy && !q.next_pat
			|=> SEQUENCE_LENGTH_FIELD == $past(q.pend_len) && !SEQ_PENDING;
	endproperty
	a_commit: assert property (p_commit) else $error("sequence not activated");

	property p_nib_bound;
		q.phase == PH_PATTERN |-> q.nib_cnt <= {1'b0, q.pend_len} + 9'h001;
	endproperty
	a_nib_bound: assert property (p_nib_bound) else $error("surplus nibble stored");

	property p_fill_zero;
		CE && {1'b0, SEQ_INDEX} >= q.act_cnt |=> SEQ_CHANNEL == 4'h0;
	endproperty
	a_fill_zero: assert property (p_fill_zero) else $error("unfilled entry not zero");

	property p_common;
		CE && q.common_input_enable && CONV_CHANNEL != 4'hF
			|=> CODING.vs_common && !CODING.bipolar && !CODING.pair;
	endproperty
	a_common: assert property (p_common) else $error("common mode coding wrong");

	property p_precedence;
		CE && !q.common_input_enable
			&& q.pair_pseudo_diff_bit[3'h7 - CONV_CHANNEL[3:1]]
			|=> CODING.pair && !CODING.bipolar;
	endproperty
	a_precedence: assert property (p_precedence) else $error("pseudo-diff lost precedence");

	property p_bitmap;
		CE && SCAN_SEL.mode == BITMAP_SCAN_EXT_CLK
			|=> SEL_MASK == $past(SCAN_SEL.custom_channel_bitmap);
	endproperty
	a_bitmap: assert property (p_bitmap) else $error("bitmap not used");

	property p_invalid;
		CE && word_done && word[15] && CONV_BUSY
			|=> !DATA_VALID ##1 (!DATA_VALID || $past(MODE_STROBE) || MODE_STROBE);
	endproperty
	a_invalid: assert property (p_invalid) else $error("data valid after config");

	property p_mode_valid;
		MODE_STROBE |-> DATA_VALID && $past(q.bitcnt) == `LAST_WORD_BIT;
	endproperty
	a_mode_valid: assert property (p_mode_valid) else $error("mode word without valid");

	// A bipolar-only pair must come out fully differential in two's complement.
	property p_fully_diff;
		CE && !q.common_input_enable && !q.pair_pseudo_diff_bit[3'h7 - CONV_CHANNEL[3:1]]
			&& q.pair_fully_diff_bit[3'h7 - CONV_CHANNEL[3:1]]
			|=> CODING.pair && CODING.bipolar && !CODING.vs_common;
	endproperty
	a_fully_diff: assert property (p_fully_diff) else $error("bipolar pair coding wrong");

	// With every bit of the pair clear the channel stays single-ended.
	property p_single;
		CE && !q.common_input_enable && !q.pair_pseudo_diff_bit[3'h7 - CONV_CHANNEL[3:1]]
			&& !q.pair_fully_diff_bit[3'h7 - CONV_CHANNEL[3:1]] |=> CODING == 3'h0;
	endproperty
	a_single: assert property (p_single) else $error("single-ended coding wrong");

	property p_pick;
		CE && SCAN_SEL.mode == SCAN_MANUAL
			|=> SEL_MASK == 16'h0001 << $past(SCAN_SEL.single_channel_pick);
	endproperty
	a_pick: assert property (p_pick) else $error("pick field not used");

	// Surplus nibbles must never reach the sequence memory.
	property p_surplus;
		CE && sck_rise && q.phase == PH_PATTERN && q.nib_cnt > {1'b0, q.pend_len} |-> !mem_we;
	endproperty
	a_surplus: assert property (p_surplus) else $error("surplus nibble written");

	// The count of whole nibbles is kept at frame end, so a cut one reads as zero.
	property p_cut;
		CE && cs_rise && q.phase == PH_PATTERN
			|=> q.pend_cnt == $past(q.nib_cnt) && q.pend_rdy;
	endproperty
	a_cut: assert property (p_cut) else $error("partial nibble counted");

endmodule // adc_input_config_sequencer

// file: adc_input_config_sequencer_tb.sv
`timescale 1ns/100ps
`include "adc_cfg_regs.svh"
module adc_input_config_sequencer_tb;
	import adc_cfg_pkg::*;
	logic clock, rst, ce, conv_busy;
	wire cs_n, sclk, din;
	scan_sel_t scan_sel;
	logic [3:0] conv_channel, seq_channel;
	logic [7:0] seq_index, sequence_length_field, cur_len;
	logic [15:0] sel_mask, u, b;
	coding_t coding;
	logic seq_pending, data_valid, mode_strobe;
	logic [14:0] mode_word;
	int seed = 32'h51DE;
	int num_errors = 0;
	int n_compared = 0;
	typedef struct packed {logic [2:0] kind; logic [15:0] val;} note_t;
	note_t notes[$];
	logic [14:0] mode_notes[$];
	event look_ev;

	adc_link_host host (.CS_N(cs_n), .SCLK(sclk), .DIN(din));
	adc_input_config_sequencer dut (.CLOCK(clock), .RST(rst), .CE(ce), .CS_N(cs_n),
		.SCLK(sclk), .DIN(din), .CONV_BUSY(conv_busy), .SCAN_SEL(scan_sel),
		.CONV_CHANNEL(conv_channel), .SEQ_INDEX(seq_index), .SEL_MASK(sel_mask),
		.CODING(coding), .SEQ_CHANNEL(seq_channel), .SEQUENCE_LENGTH_FIELD(sequence_length_field),
		.SEQ_PENDING(seq_pending), .DATA_VALID(data_valid), .MODE_WORD(mode_word),
		.MODE_STROBE(mode_strobe));

	// ************************************************************
	// Clock, checking and closing.
	// ************************************************************
	// The clock runs at 100 MHz.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Notes left unanswered mean a result never appeared, so they count as mismatches.
	task automatic print_verdict();
		num_errors += notes.size() + mode_notes.size();
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Lookup results are taken off the queue oldest first.
	always @(look_ev) begin
		note_t n;
		n = notes.pop_front();
		case (n.kind)
			3'h0: compare(sel_mask, n.val);
			3'h1: compare({13'h0, coding}, n.val);
			3'h2: compare({12'h0, seq_channel}, n.val);
			3'h3: compare({8'h0, sequence_length_field}, n.val);
			3'h4: compare({15'h0, seq_pending}, n.val);
			default: compare({15'h0, data_valid}, n.val);
		endcase
	end
	// A mode strobe is the result that answers the oldest mode note.
	always @(negedge clock) begin
		if (mode_strobe === 1'b1) begin
			if (mode_notes.size() == 0)
				compare(16'hFFFF, 16'h0);
			else
				compare({1'b0, mode_word}, {1'b0, mode_notes.pop_front()});
		end
	end
	// A hang is cut short here and counts as a mismatch.
	initial begin
		#500000;
		num_errors++;
		print_verdict();
	end

	// ************************************************************
	// Stimulus tasks.
	// ************************************************************
	// The #1 lets the monitor take this note before the next one is queued.
	task automatic look(input logic [2:0] kind, input logic [15:0] val);
		@(negedge clock);
		notes.push_back({kind, val});
		->look_ev;
		#1;
	endtask
	task automatic wr(input logic [15:0] w);
		host.frame(1024'(w), 16);
		repeat (8) @(negedge clock);
	endtask
	task automatic mode(input logic [14:0] w);
		mode_notes.push_back(w);
		wr({1'b0, w});
	endtask
	function automatic coding_t exp_code(input logic [3:0] ch);
		logic pu, pb;
		pu = u[3 + 7 - ch[3:1]];
		pb = b[3 + 7 - ch[3:1]];
		if (u[2] && ch != 4'hF)
			return 3'b001;
		return {pu | pb, pb & ~pu, 1'b0};
	endfunction
	task automatic seq_case(input logic [7:0] len, input int k, input int cut);
		logic [1023:0] p;
		logic [3:0] nib [256];
		p = '0;
		wr({`SEQUENCE_LENGTH_CODE, len, 3'h5});
		for (int i = 0; i < k; i++) begin
			nib[i] = 4'($random(seed));
			p = {p[1019:0], nib[i]};
		end
		if (cut != 0)
			p = {p[1021:0], 2'h3};
		host.frame(p, 4 * k + 2 * cut);
		repeat (8) @(negedge clock);
		look(3'h4, 16'h1);
		look(3'h3, {8'h0, cur_len});
		mode(15'($random(seed)));
		cur_len = len;
		look(3'h4, 16'h0);
		look(3'h3, {8'h0, len});
		for (int i = 0; i <= len + 1 && i < 256; i++) begin
			seq_index = 8'(i);
			look(3'h2, 16'((i <= len && i < k) ? nib[i] : 4'h0));
		end
	endtask

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		conv_busy = 1'b0;
		scan_sel = '0;
		conv_channel = 4'h0;
		seq_index = 8'h0;
		cur_len = 8'h0;
		u = 16'h0;
		b = 16'h0;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		look(3'h1, 16'h0);
		look(3'h3, 16'h0);
		look(3'h5, 16'h0);
		for (int m = 0; m < 8; m++) begin
			scan_sel = {scan_mode_t'(m), 4'($random(seed)), 16'($random(seed))};
			look(3'h0, (m > 5) ? scan_sel.custom_channel_bitmap
				: 16'h1 << scan_sel.single_channel_pick);
		end
		for (int t = 0; t < 6; t++) begin
			u = {`PSEUDO_DIFF_SELECT_CODE, 11'($random(seed))};
			u[2] = t[0];
			b = {`FULLY_DIFF_SELECT_CODE, 11'($random(seed))};
			wr(u);
			wr(b);
			for (int ch = 0; ch < 16; ch++) begin
				conv_channel = 4'(ch);
				look(3'h1, {13'h0, exp_code(4'(ch))});
			end
		end
		// With the clock enable low the last coding must stand though the channel moves.
		ce = 1'b0;
		conv_channel = 4'h0;
		look(3'h1, {13'h0, exp_code(4'hF)});
		ce = 1'b1;
		conv_channel = 4'hF;
		seq_case(8'd9, 5, 1);
		seq_case(8'd3, 7, 0);
		seq_case(8'd255, 256, 0);
		conv_busy = 1'b1;
		wr(b);
		look(3'h5, 16'h0);
		mode(15'h2A5C);
		look(3'h5, 16'h1);
		conv_busy = 1'b0;
		wr(u);
		look(3'h5, 16'h1);
		print_verdict();
	end
endmodule // adc_input_config_sequencer_tb

// file: adc_link_host.sv
`timescale 1ns/100ps
module adc_link_host (
	output logic CS_N,
	output logic SCLK,
	output logic DIN
);
	// ************************************************************
	// Serial host on the far side of the link.
	// ************************************************************
	// The link clock idles low and stands still between frames.
	initial begin
		CS_N = 1'b1;
		SCLK = 1'b0;
		DIN = 1'b0;
	end
	// One chip-select frame of n bits, sent MSB first from bits[n-1] down.
	task automatic frame(input logic [1023:0] bits, input int n);
		CS_N = 1'b0;
		#62.5;
		for (int i = n - 1; i >= 0; i--) begin
			DIN = bits[i];
			#62.5 SCLK = 1'b1;
			#62.5 SCLK = 1'b0;
		end
		#62.5 CS_N = 1'b1;
		// A released data line must not keep showing its last bit.
		DIN = ~DIN;
		#250;
	endtask
endmodule // adc_link_host
